// [shared/batt_status_pkg.sv]
// Constants and carrier types for the battery status command registers
package batt_status_pkg;

    // Command codes
    localparam logic [7:0] CMD_PACK_CAPACITY_AT_FULL   = 8'h10;
    localparam logic [7:0] CMD_MINUTES_LEFT_NOW        = 8'h11;
    localparam logic [7:0] CMD_MINUTES_LEFT_AVERAGED   = 8'h12;
    localparam logic [7:0] CMD_MINUTES_UNTIL_FULL      = 8'h13;
    localparam logic [7:0] CMD_REQUESTED_CHARGE_MA     = 8'h14;
    localparam logic [7:0] CMD_REQUESTED_CHARGE_MV     = 8'h15;
    localparam logic [7:0] CMD_ALARM_AND_FLAG_WORD     = 8'h16;

    // Status word bit positions
    localparam int BIT_OVERCHARGE    = 15;
    localparam int BIT_STOP_CHARGE   = 14;
    localparam int BIT_OVER_TEMP     = 12;
    localparam int BIT_STOP_DISCH    = 11;
    localparam int BIT_LOW_CAPACITY  = 9;
    localparam int BIT_LOW_TIME      = 8;
    localparam int BIT_FLASH_VALID   = 7;
    localparam int BIT_NOT_CHARGING  = 6;
    localparam int BIT_FULL          = 5;
    localparam int BIT_EMPTY         = 4;
    localparam int ERR_LSB           = 0;

    // Special values
    localparam logic [15:0] WORD_INVALID   = 16'hffff;
    localparam logic [15:0] WORD_MAX_VALID = 16'hfffe;
    localparam logic [2:0]  ERR_ALL_ONES   = 3'h7;
    localparam logic [15:0] RESET_WORD     = 16'h0000;

    // Overcharge clears after this much continuous discharge, in uAh
    localparam logic [15:0] OVERCHG_CLR_UAH = 16'h07d0;
    // Empty flag clears at this relative state of charge, in percent
    localparam logic [7:0]  EMPTY_CLR_PCT   = 8'h14;

    typedef enum logic [2:0] {
        ERR_OK, ERR_BUSY, ERR_RESERVED_CMD, ERR_UNSUPPORTED,
        ERR_ACCESS_DENIED, ERR_OVER_UNDER, ERR_BAD_SIZE, ERR_UNKNOWN
    } err_code_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        reserved;
        logic [7:0]  code;
    } cmd_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } cmd_rsp_t;

    typedef struct packed {
        logic        send;
        logic [15:0] word;
    } alarm_msg_t;

    typedef struct packed {
        logic        capacityPower;
        logic        charging;
        logic        discharging;
        logic        busy;
        logic        overflowEvt;
        logic        unknownEvt;
        logic        flashLoadValid;
        logic [15:0] fullCapMah;
        logic [15:0] fullCapCwh;
        logic [15:0] runMinCur;
        logic [15:0] runMinPow;
        logic [15:0] avgMinCur;
        logic [15:0] avgMinPow;
        logic [15:0] fullMin;
        logic [15:0] chargeMa;
        logic [15:0] chargeMv;
        logic [15:0] chargeLeftMah;
        logic [15:0] chargeLeftCwh;
        logic [15:0] capacityAlarmThreshold;
        logic [15:0] timeAlarmThreshold;
        logic        overchargeDetect;
        logic [15:0] contDischUah;
        logic        primaryTermination;
        logic [15:0] temperature;
        logic [15:0] otChgSet;
        logic [15:0] otChgReset;
        logic [15:0] otDsgSet;
        logic [15:0] otDsgReset;
        logic [15:0] suspendTempLow;
        logic [15:0] voltage;
        logic [15:0] terminateVoltage;
        logic [15:0] remainingCharge;
        logic        cellUndervoltageFlag;
        logic        emptyDetect;
        logic [7:0]  relSoc;
        logic [7:0]  fullClearPct;
    } gauge_in_t;

endpackage

// [core/battery_status_command_set.sv]
// Read-only battery status command registers and alarm flag logic
`timescale 1ns/100ps
// What this block does
// R1 - Code 0x10 returns full-charge capacity in mAh or 10 mWh by mode
// R2 - Code 0x11 returns run minutes, capped 65534, 65535 when not discharging
// R3 - Code 0x12 returns smoothed minutes left, 65535 when not discharging
// R4 - Code 0x13 returns minutes to full, 65535 when not charging
// R5 - Code 0x14 returns requested charge mA; 0 stops, 65535 means CV
// R6 - Code 0x15 returns requested charge mV; 65535 means CC source
// R7 - Every read command gets a read-word answer of one unsigned 16-bit word; writes get no answer
// R8 - Alarm flags sit at bits 15,14,12,11,9,8; 13 and 10 reserved
// R9 - Status flags sit at bits 7,6,5,4
// R10 - Low three bits hold the outcome code of the last command
// R11 - Alarm broadcast sends the previous cycle's status word, without the newly risen bit, with error bits forced high
// R12 - Capacity and time alarms use current or power per the mode bit
// R13 - Overcharge sets past limit, clears after stop plus 2 mAh discharge
// R14 - Stop-charge sets on primary termination, clears when not charging
// R15 - Over-temperature sets at threshold per direction, clears below reset
// R16 - Stop-discharge sets on zero charge, terminate volts, cold or undervolt
// R17 - Stop-discharge clears only when all three release conditions hold
// R18 - Low-capacity sets below threshold, clears on lower threshold or charge
// R19 - Low-time sets below threshold, clears on lower threshold or charge
// R20 - Not-charging flag follows the charging detection
// R21 - Empty flag clears once relative charge reaches 20 percent
// R22 - Reserved and unused status bits read as zero
module battery_status_command_set (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire batt_status_pkg::cmd_req_t  cmdReq,
    input  wire batt_status_pkg::gauge_in_t gauge,
    output batt_status_pkg::cmd_rsp_t       cmdRsp,
    output batt_status_pkg::alarm_msg_t     alarmMsg
);
    import batt_status_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        cmd_rsp_t    rsp;
        alarm_msg_t  alarm;
        err_code_t   err;
        logic        overcharge;
        logic        stopCharge;
        logic        overTemp;
        logic        overTempFromChg;
        logic        stopDisch;
        logic        lowCapacity;
        logic        lowTime;
        logic        full;
        logic        empty;
        logic [15:0] lastChargeLeft;
        logic [15:0] lastAvgMin;
    } state_t;

    state_t stateR;
    state_t stateNxt;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] clampMinutes(
        input logic        active,
        input logic [15:0] minutes
    );
        if (!active) begin
            return WORD_INVALID;
        end
        return (minutes > WORD_MAX_VALID) ? WORD_MAX_VALID : minutes;
    endfunction

    function automatic logic [15:0] byMode(
        input logic        power,
        input logic [15:0] curVal,
        input logic [15:0] powVal
    );
        return power ? powVal : curVal;
    endfunction

    function automatic logic inRange(input logic [7:0] code);
        return code >= CMD_PACK_CAPACITY_AT_FULL &&
               code <= CMD_ALARM_AND_FLAG_WORD;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Mode-selected values

    logic [15:0] chargeLeft;
    logic [15:0] runMin;
    logic [15:0] avgMin;
    logic [15:0] statusWord;
    logic        alarmRise;

    assign chargeLeft = byMode(gauge.capacityPower, gauge.chargeLeftMah,
                               gauge.chargeLeftCwh); // R12
    assign runMin     = byMode(gauge.capacityPower, gauge.runMinCur,
                               gauge.runMinPow); // R12
    assign avgMin     = byMode(gauge.capacityPower, gauge.avgMinCur,
                               gauge.avgMinPow); // R12

    ////////////////////////////////////////////////////////////////////
    // Status word

    always_comb begin
        statusWord = RESET_WORD; // R22
        statusWord[BIT_OVERCHARGE]   = stateR.overcharge; // R8
        statusWord[BIT_STOP_CHARGE]  = stateR.stopCharge; // R8
        statusWord[BIT_OVER_TEMP]    = stateR.overTemp; // R8
        statusWord[BIT_STOP_DISCH]   = stateR.stopDisch; // R8
        statusWord[BIT_LOW_CAPACITY] = stateR.lowCapacity; // R8
        statusWord[BIT_LOW_TIME]     = stateR.lowTime; // R8
        statusWord[BIT_FLASH_VALID]  = gauge.flashLoadValid; // R9
        statusWord[BIT_NOT_CHARGING] = !gauge.charging; // R9 R20
        statusWord[BIT_FULL]         = stateR.full; // R9
        statusWord[BIT_EMPTY]        = stateR.empty; // R9
        statusWord[ERR_LSB +: 3]     = stateR.err; // R10
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        stateNxt = stateR;
        stateNxt.rsp.valid  = 1'b0;
        stateNxt.alarm.send = 1'b0;
        stateNxt.lastChargeLeft = chargeLeft;
        stateNxt.lastAvgMin     = avgMin;

        // Command answer, one cycle after the request
        if (cmdReq.valid) begin
            stateNxt.rsp.valid = !cmdReq.write; // R7
            unique case (cmdReq.code)
                CMD_PACK_CAPACITY_AT_FULL:
                    stateNxt.rsp.data = byMode(gauge.capacityPower,
                        gauge.fullCapMah, gauge.fullCapCwh); // R1
                CMD_MINUTES_LEFT_NOW:
                    stateNxt.rsp.data =
                        clampMinutes(gauge.discharging, runMin); // R2
                CMD_MINUTES_LEFT_AVERAGED:
                    stateNxt.rsp.data =
                        clampMinutes(gauge.discharging, avgMin); // R3
                CMD_MINUTES_UNTIL_FULL:
                    stateNxt.rsp.data =
                        clampMinutes(gauge.charging, gauge.fullMin); // R4
                CMD_REQUESTED_CHARGE_MA:
                    stateNxt.rsp.data = gauge.chargeMa; // R5
                CMD_REQUESTED_CHARGE_MV:
                    stateNxt.rsp.data = gauge.chargeMv; // R6
                CMD_ALARM_AND_FLAG_WORD:
                    stateNxt.rsp.data = statusWord; // R8 R9 R10
                default:
                    stateNxt.rsp.data = RESET_WORD;
            endcase
            // Outcome of this command
            if (gauge.busy) begin
                stateNxt.err = ERR_BUSY; // R10
            end else if (cmdReq.reserved) begin
                stateNxt.err = ERR_RESERVED_CMD; // R10
            end else if (!inRange(cmdReq.code)) begin
                stateNxt.err = ERR_UNSUPPORTED; // R10
            end else if (cmdReq.write) begin
                stateNxt.err = ERR_ACCESS_DENIED; // R7 R10
            end else begin
                stateNxt.err = ERR_OK; // R10
            end
        end
        if (gauge.overflowEvt) begin
            stateNxt.err = ERR_OVER_UNDER; // R10
        end
        if (gauge.unknownEvt) begin
            stateNxt.err = ERR_UNKNOWN; // R10
        end

        // Overcharge
        if (gauge.overchargeDetect) begin
            stateNxt.overcharge = 1'b1; // R13
        end else if (!gauge.charging &&
                     gauge.contDischUah >= OVERCHG_CLR_UAH) begin
            stateNxt.overcharge = 1'b0; // R13
        end

        // Stop charge
        if (gauge.primaryTermination) begin
            stateNxt.stopCharge = 1'b1; // R14
        end else if (!gauge.charging) begin
            stateNxt.stopCharge = 1'b0; // R14
        end

        // Over temperature, set wins over clear
        if (gauge.charging && gauge.temperature >= gauge.otChgSet) begin
            stateNxt.overTemp        = 1'b1; // R15
            stateNxt.overTempFromChg = 1'b1;
        end else if (gauge.discharging &&
                     gauge.temperature >= gauge.otDsgSet) begin
            stateNxt.overTemp        = 1'b1; // R15
            stateNxt.overTempFromChg = 1'b0;
        end else if (stateR.overTemp) begin
            if (stateR.overTempFromChg ?
                gauge.temperature < gauge.otChgReset :
                gauge.temperature < gauge.otDsgReset) begin
                stateNxt.overTemp = 1'b0; // R15
            end
        end

        // Stop discharge
        if (gauge.remainingCharge == 16'h0000 ||
            gauge.voltage == gauge.terminateVoltage ||
            gauge.temperature <= gauge.suspendTempLow ||
            gauge.cellUndervoltageFlag) begin
            stateNxt.stopDisch = 1'b1; // R16
        end else if (gauge.voltage > gauge.terminateVoltage &&
                     gauge.remainingCharge > 16'h0000 &&
                     !gauge.cellUndervoltageFlag) begin
            stateNxt.stopDisch = 1'b0; // R17
        end

        // Low capacity
        if (chargeLeft < gauge.capacityAlarmThreshold) begin
            stateNxt.lowCapacity = 1'b1; // R18
        end else if (gauge.capacityAlarmThreshold < chargeLeft ||
                     (gauge.charging &&
                      chargeLeft > stateR.lastChargeLeft)) begin
            stateNxt.lowCapacity = 1'b0; // R18
        end

        // Low time
        if (gauge.discharging && runMin < gauge.timeAlarmThreshold) begin
            stateNxt.lowTime = 1'b1; // R19
        end else if (gauge.timeAlarmThreshold < avgMin ||
                     (gauge.charging && avgMin > stateR.lastAvgMin)) begin
            stateNxt.lowTime = 1'b0; // R19
        end

        // Full and empty
        if (gauge.primaryTermination || gauge.overchargeDetect) begin
            stateNxt.full = 1'b1;
        end else if (gauge.relSoc < gauge.fullClearPct) begin
            stateNxt.full = 1'b0;
        end
        if (gauge.emptyDetect) begin
            stateNxt.empty = 1'b1;
        end else if (gauge.relSoc >= EMPTY_CLR_PCT) begin
            stateNxt.empty = 1'b0; // R21
        end

        // Broadcast when any alarm bit rises
        stateNxt.alarm.word = {statusWord[15:3], ERR_ALL_ONES}; // R11
        alarmRise =
            (!stateR.overcharge  && stateNxt.overcharge)  ||
            (!stateR.stopCharge  && stateNxt.stopCharge)  ||
            (!stateR.overTemp    && stateNxt.overTemp)    ||
            (!stateR.stopDisch   && stateNxt.stopDisch)   ||
            (!stateR.lowCapacity && stateNxt.lowCapacity) ||
            (!stateR.lowTime     && stateNxt.lowTime);
        stateNxt.alarm.send = alarmRise; // R11
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateR <= '0;
        end else begin
            stateR <= stateNxt;
        end
    end

    assign cmdRsp   = stateR.rsp;
    assign alarmMsg = stateR.alarm;

endmodule

// [sim/batt_status_props.sv]
// Concurrent checks on the battery status command set ports
`timescale 1ns/100ps
module batt_status_props (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire batt_status_pkg::cmd_req_t   cmdReq,
    input wire batt_status_pkg::gauge_in_t  gauge,
    input wire batt_status_pkg::cmd_rsp_t   cmdRsp,
    input wire batt_status_pkg::alarm_msg_t alarmMsg
);
    import batt_status_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    sequence s_rd(c);
        cmdReq.valid && !cmdReq.write && cmdReq.code == c;
    endsequence
    sequence s_any_rd;
        cmdReq.valid && !cmdReq.write;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_any_rd |=> cmdRsp.valid)
        else $error("read got no answer");
    a_write_silent: assert property (
        cmdReq.valid && cmdReq.write |=> !cmdRsp.valid)
        else $error("write was answered");
    a_no_spurious: assert property (!cmdReq.valid |=> !cmdRsp.valid)
        else $error("answer without request");
    a_run_invalid: assert property (
        s_rd(8'h11) ##0 !gauge.discharging |=> cmdRsp.data == 16'hffff)
        else $error("run minutes not invalid");
    a_full_invalid: assert property (
        s_rd(8'h13) ##0 !gauge.charging |=> cmdRsp.data == 16'hffff)
        else $error("minutes to full not invalid");
    a_bad_code_zero: assert property (
        s_any_rd ##0 (cmdReq.code < 8'h10 || cmdReq.code > 8'h16)
        |=> cmdRsp.data == 16'h0000)
        else $error("unsupported read not zero");
    a_err_ones: assert property (
        $past(rst_n, 2) |-> alarmMsg.word[2:0] == 3'h7)
        else $error("broadcast error bits not all ones");
    a_resv_zero: assert property (
        !alarmMsg.word[13] && !alarmMsg.word[10] && !alarmMsg.word[3])
        else $error("reserved status bit set");
    a_not_chg_bit: assert property (
        gauge.charging [*2] |=> !alarmMsg.word[BIT_NOT_CHARGING])
        else $error("not-charging flag while charging");
    a_send_rise: assert property (
        $rose(alarmMsg.word[BIT_OVERCHARGE])
        |-> $past(alarmMsg.send) or ##[0:1] alarmMsg.send)
        else $error("no broadcast on alarm rise");
endmodule
bind battery_status_command_set batt_status_props i_props (
    .clk(clk), .rst_n(rst_n), .cmdReq(cmdReq), .gauge(gauge),
    .cmdRsp(cmdRsp), .alarmMsg(alarmMsg));

// [sim/smbus_host_model.sv]
// Host side model issuing read-word and write requests
`timescale 1ns/100ps
module smbus_host_model (
    input  wire logic                  clk,
    output batt_status_pkg::cmd_req_t  cmdReq
);
    import batt_status_pkg::*;
    initial cmdReq = '0;
    // Called at a falling edge; gap 0 keeps the strobe up back to back
    task automatic issue(input logic [7:0] c, input logic wr, rsv,
                         input int gap);
        cmdReq <= '{1'b1, wr, rsv, c};
        @(negedge clk);
        if (gap > 0) begin
            cmdReq <= '{1'b0, 1'b0, 1'b0, ~c};
            repeat (gap) @(negedge clk);
        end
    endtask
endmodule

// [sim/tb_battery_status_command_set.sv]
// Self-checking bench for the battery status command set
`timescale 1ns/100ps
module tb_battery_status_command_set;
    import batt_status_pkg::*;
    typedef struct packed {logic [15:0] e; logic [15:0] m;} note_t;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    gauge_in_t  gauge = '0;
    cmd_req_t   cmdReq;
    cmd_rsp_t   cmdRsp;
    alarm_msg_t alarmMsg;
    note_t      notes[$];
    int         failures = 0;
    int         comparisons = 0;
    int         cycles = 0;
    logic [2:0] ek[7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0};
    logic [415:0] r;
    ////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    battery_status_command_set i_dut (.clk(clk), .rst_n(rst_n),
        .cmdReq(cmdReq), .gauge(gauge), .cmdRsp(cmdRsp),
        .alarmMsg(alarmMsg));
    smbus_host_model i_host (.clk(clk), .cmdReq(cmdReq));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, exp, msk);
        comparisons++;
        if ((got & msk) !== (exp & msk)) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd(input logic [7:0] c, input logic wr, rsv,
                      input logic [15:0] e, m, input int g);
        if (!wr)
            notes.push_back('{e, m});
        i_host.issue(c, wr, rsv, g);
    endtask
    task automatic flag(input logic [15:0] msk, input logic on);
        repeat (3) @(negedge clk);
        check(alarmMsg.word, on ? msk : 16'h0000, msk);
    endtask
    function automatic logic [15:0] mn(input logic [15:0] v);
        return (v == 16'hffff) ? 16'hfffe : v;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
        if (rst_n && cmdRsp.valid === 1'b1) begin
            if (notes.size() == 0)
                check(16'h0001, 16'h0000, 16'hffff);
            else
                check(cmdRsp.data, notes[0].e, notes[0].m);
            if (notes.size() != 0)
                void'(notes.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(89));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 13; i++)
                r[i*32+:32] = $urandom;
            gauge = r[$bits(gauge_in_t)-1:0];
            {gauge.busy, gauge.overflowEvt, gauge.unknownEvt} = 3'h0;
            {gauge.charging, gauge.discharging} = 2'b01;
            gauge.capacityPower = p[0];
            rd(8'h10, 0, 0, p ? gauge.fullCapCwh : gauge.fullCapMah,
               16'hffff, 0);
            rd(8'h11, 0, 0, mn(p ? gauge.runMinPow : gauge.runMinCur),
               16'hffff, 0);
            rd(8'h12, 0, 0, mn(p ? gauge.avgMinPow : gauge.avgMinCur),
               16'hffff, 0);
            rd(8'h13, 0, 0, 16'hffff, 16'hffff, 0);
            rd(8'h14, 0, 0, gauge.chargeMa, 16'hffff, 0);
            rd(8'h15, 0, 0, gauge.chargeMv, 16'hffff, 1);
        end
        {gauge.charging, gauge.discharging} = 2'b10;
        {gauge.chargeMa, gauge.chargeMv} = {16'h0000, 16'hffff};
        gauge.flashLoadValid = 1'b1;
        rd(8'h11, 0, 0, 16'hffff, 16'hffff, 0);
        rd(8'h12, 0, 0, 16'hffff, 16'hffff, 0);
        rd(8'h13, 0, 0, mn(gauge.fullMin), 16'hffff, 0);
        rd(8'h14, 0, 0, 16'h0000, 16'hffff, 0);
        gauge.chargeMa = 16'hffff;
        rd(8'h14, 0, 0, 16'hffff, 16'hffff, 0);
        rd(8'h15, 0, 0, 16'hffff, 16'hffff, 3);
        for (int k = 0; k < 7; k++) begin
            gauge.busy = (k == 0);
            gauge.overflowEvt = (k == 4);
            gauge.unknownEvt = (k == 5);
            rd((k == 2) ? 8'h30 : 8'h10, k == 3, k == 1, 16'h0000,
               (k == 2) ? 16'hffff : 16'h0000, 0);
            {gauge.busy, gauge.overflowEvt, gauge.unknownEvt} = 3'h0;
            rd(8'h16, 0, 0, {13'h0010, ek[k]}, 16'h24cf, 1);
        end
        check(alarmMsg.word, 16'h0087, 16'h24cf);
        gauge.overchargeDetect = 1'b1;
        flag(16'h8000, 1);
        gauge.overchargeDetect = 1'b0;
        {gauge.charging, gauge.discharging} = 2'b01;
        gauge.contDischUah = 16'h07cf;
        flag(16'h8000, 1);
        gauge.contDischUah = 16'h07d0;
        flag(16'h8000, 0);
        {gauge.voltage, gauge.terminateVoltage} = {16'h3000, 16'h2000};
        {gauge.temperature, gauge.suspendTempLow} = {16'h0bb8, 16'h0a00};
        gauge.remainingCharge = 16'h0100;
        gauge.cellUndervoltageFlag = 1'b0;
        flag(16'h0800, 0);
        gauge.remainingCharge = 16'h0000;
        flag(16'h0800, 1);
        gauge.remainingCharge = 16'h0064;
        gauge.cellUndervoltageFlag = 1'b1;
        flag(16'h0800, 1);
        gauge.cellUndervoltageFlag = 1'b0;
        flag(16'h0800, 0);
        gauge.voltage = 16'h2000;
        flag(16'h0800, 1);
        {gauge.emptyDetect, gauge.relSoc} = {1'b1, 8'h0a};
        flag(16'h0010, 1);
        {gauge.emptyDetect, gauge.relSoc} = {1'b0, 8'h13};
        flag(16'h0010, 1);
        gauge.relSoc = 8'h14;
        flag(16'h0010, 0);
        {gauge.charging, gauge.discharging} = 2'b10;
        gauge.primaryTermination = 1'b1;
        flag(16'h4000, 1);
        gauge.primaryTermination = 1'b0;
        flag(16'h4000, 1);
        {gauge.otChgSet, gauge.otChgReset} = {16'h0c00, 16'h0b00};
        gauge.temperature = 16'h0c00;
        flag(16'h1000, 1);
        gauge.temperature = 16'h0b80;
        flag(16'h1000, 1);
        gauge.temperature = 16'h0aff;
        flag(16'h1000, 0);
        gauge.capacityPower = 1'b1;
        {gauge.chargeLeftCwh, gauge.chargeLeftMah} = {16'h0010, 16'h0100};
        gauge.capacityAlarmThreshold = 16'h0020;
        flag(16'h0200, 1);
        gauge.capacityPower = 1'b0;
        flag(16'h0200, 0);
        {gauge.charging, gauge.discharging} = 2'b01;
        flag(16'h4000, 0);
        {gauge.runMinCur, gauge.avgMinCur} = {16'h0005, 16'h0008};
        gauge.timeAlarmThreshold = 16'h000a;
        flag(16'h0100, 1);
        gauge.timeAlarmThreshold = 16'h0006;
        flag(16'h0100, 1);
        gauge.runMinCur = 16'h0007;
        flag(16'h0100, 0);
        wrap_up();
    end
endmodule
